// ===== include/rtcr_pkg.sv
// constants, register map and encodings of the transmit and receive configuration bank
package rtcr_pkg;

   // ***************************************************************
   // register map
   // ***************************************************************
   localparam int             ADDR_W   = 6;      // register address width
   localparam int             DATA_W   = 8;      // register data width
   localparam int             NUM_REGS = 7;      // registers in the bank
   localparam int             IDX_COND = 0;      // driver conductance slot
   localparam int             IDX_FIXA = 1;      // fixed setting a slot
   localparam int             IDX_RATE = 2;      // encoder rate slot
   localparam int             IDX_MODW = 3;      // pulse width slot
   localparam int             IDX_FIXB = 4;      // fixed setting b slot
   localparam int             IDX_FIXC = 5;      // fixed setting c slot
   localparam int             IDX_RXC1 = 6;      // receiver control one slot
   localparam logic [5:0]     REG_OFS [NUM_REGS] = '{6'h12, 6'h13, 6'h14, 6'h15,
                                                     6'h16, 6'h17, 6'h19};
   localparam logic [7:0]     REG_RST [NUM_REGS] = '{8'h3f, 8'h3f, 8'h19, 8'h13,
                                                     8'h00, 8'h00, 8'h73};
   localparam logic [7:0]     UNMAPPED_RD = 8'h00; // read value of holes

   // ***************************************************************
   // field positions
   // ***************************************************************
   localparam int             COND_LSB = 0;      // conductance field 5..0
   localparam int             RATE_LSB = 3;      // encoder rate field 5..3
   localparam int             SUBC_LSB = 5;      // subcarrier field 7..5
   localparam int             LPF_BIT  = 2;      // low-pass bypass bit
   localparam int             GAIN_LSB = 0;      // gain field 1..0

   // ***************************************************************
   // encodings
   // ***************************************************************
   localparam logic [2:0]     RATE_848  = 3'h0;  // fastest encoder rate
   localparam logic [2:0]     RATE_424  = 3'h1;
   localparam logic [2:0]     RATE_212  = 3'h2;
   localparam logic [2:0]     RATE_106  = 3'h3;  // proximity standard rate
   localparam logic [11:0]    KBD_848   = 12'h350;
   localparam logic [11:0]    KBD_424   = 12'h1a8;
   localparam logic [11:0]    KBD_212   = 12'h0d4;
   localparam logic [11:0]    KBD_106   = 12'h06a;
   localparam logic [2:0]     SUBC_MAX  = 3'h4;  // highest legal pulse code
   localparam logic [5:0]     GAIN_DB [4] = '{6'h14, 6'h18, 6'h1f, 6'h23};
   localparam logic [9:0]     MOD_SCALE = 10'h002; // periods per width step

endpackage : rtcr_pkg

// ===== rtl/rtcr_mod_pulse.sv
// modulation pulse timer, pulse length twice the width value plus two
`timescale 1ns/1ps
`default_nettype none

module rtcr_mod_pulse
   import rtcr_pkg::*;
(
   input  wire logic       ref_clk_in,        // system clock
   input  wire logic       rst_n_in,          // synchronous reset, low
   input  wire logic       start_in,          // request one pulse
   input  wire logic [7:0] width_in,          // pulse width value
   output logic            pulse_out          // modulation pulse
);

   typedef enum logic [0:0] {
      MP_IDLE   = 1'b0,                       // waiting for a request
      MP_ACTIVE = 1'b1                        // pulse in progress
   } rtcr_mp_e;

   typedef struct packed {
      rtcr_mp_e   state;                      // timer state
      logic [8:0] remain;                     // cycles left minus one
      logic [7:0] width_lat;                  // width taken at start
      logic [9:0] len;                        // cycles high so far
   } rtcr_mp_s;

   rtcr_mp_s st_reg;                          // present state
   rtcr_mp_s st_next;                         // next state

   always_comb begin
      st_next = st_reg;
      unique case (st_reg.state)
         MP_IDLE: begin
            // a request while busy is ignored, width latched here
            if (start_in) begin
               st_next.state     = MP_ACTIVE;
               st_next.remain    = {width_in, 1'b1};
               st_next.width_lat = width_in;
               st_next.len       = 10'h000;
            end
         end
         MP_ACTIVE: begin
            st_next.len = st_reg.len + 10'h001;
            if (st_reg.remain == 9'h000) begin
               st_next.state = MP_IDLE;
            end else begin
               st_next.remain = st_reg.remain - 9'h001;
            end
         end
      endcase
   end

   // state register
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         st_reg <= '{MP_IDLE, 9'h000, 8'h00, 10'h000};
      end else begin
         st_reg <= st_next;
      end
   end

   assign pulse_out = (st_reg.state == MP_ACTIVE);

   // ***************************************************************
   // checks
   // ***************************************************************
   sequence s_mp_start;
      start_in && (st_reg.state == MP_IDLE);
   endsequence

   a_pulse_starts: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      s_mp_start |=> pulse_out [*2])
      else $error("modulation pulse did not start for two cycles");
   a_pulse_length: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      $fell(pulse_out) |-> (st_reg.len == MOD_SCALE * ({2'b00, st_reg.width_lat} + 10'h001)))
      else $error("modulation pulse length wrong");

endmodule : rtcr_mod_pulse

`default_nettype wire

// ===== rtl/rtcr_reg_cell.sv
// one eight-bit configuration register with its own reset value
`timescale 1ns/1ps
`default_nettype none

module rtcr_reg_cell
   import rtcr_pkg::*;
#(
   parameter logic [7:0] RESET_VAL = 8'h00    // value after reset
) (
   input  wire logic       ref_clk_in,        // system clock
   input  wire logic       rst_n_in,          // synchronous reset, low
   input  wire logic       wr_en_in,          // write this cell
   input  wire logic [7:0] wdata_in,          // write data
   output logic      [7:0] value_out          // stored value
);

   typedef struct packed {
      logic [7:0] value;                      // stored byte
   } rtcr_cell_s;

   rtcr_cell_s st_reg;                        // present state
   rtcr_cell_s st_next;                       // next state

   // load on write, otherwise hold
   always_comb begin
      st_next = st_reg;
      if (wr_en_in) begin
         st_next.value = wdata_in;
      end
   end

   // state register
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         st_reg.value <= RESET_VAL;
      end else begin
         st_reg <= st_next;
      end
   end

   assign value_out = st_reg.value;

endmodule : rtcr_reg_cell

`default_nettype wire

// ===== rtl/rtcr_top.sv
// transmit and receive configuration register bank with its decoded outputs
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module rtcr_top
   import rtcr_pkg::*;
(
   input  wire logic              ref_clk_in,   // system clock
   input  wire logic              rst_n_in,     // synchronous reset, low
   input  wire logic [ADDR_W-1:0] reg_addr_in,  // register address
   input  wire logic [7:0]        reg_wdata_in, // write data
   input  wire logic              reg_wr_in,    // write strobe
   input  wire logic              reg_rd_in,    // read strobe
   output logic      [7:0]        reg_rdata_out,  // read data, cycle after
   input  wire logic              mod_start_in, // request modulation pulse
   output logic                   mod_pulse_out,  // modulation pulse
   output logic      [5:0]        driver_conductance_setting_out, // drive
   output logic      [2:0]        encoder_bit_rate_out,       // rate code
   output logic      [11:0]       encoder_rate_kbd_out,       // rate kBd
   output logic                   encoder_rate_reserved_out,  // bad code
   output logic      [7:0]        mod_pulse_width_count_out,  // width
   output logic      [2:0]        subcarrier_pulse_count_out, // code
   output logic      [4:0]        subcarrier_pulses_out,      // per bit
   output logic                   subcarrier_reserved_out,    // bad code
   output logic                   lowpass_bypass_out,         // filter off
   output logic      [1:0]        rx_gain_code_out,           // gain code
   output logic      [5:0]        rx_gain_db_out              // gain in dB
);

   // ***************************************************************
   // state of the decode and read path
   // ***************************************************************
   typedef struct packed {
      logic [7:0]  rd_data;                   // read answer
      logic [11:0] rate_kbd;                  // decoded encoder rate
      logic        rate_rsvd;                 // reserved rate code seen
      logic [4:0]  subc_num;                  // decoded pulses per bit
      logic        subc_rsvd;                 // reserved pulse code seen
      logic [5:0]  gain_db;                   // decoded gain
   } rtcr_top_s;

   rtcr_top_s  st_reg;                        // present state
   rtcr_top_s  st_next;                       // next state
   logic [7:0] reg_val [NUM_REGS];            // stored register values
   logic       reg_hit [NUM_REGS];            // address matches slot
   logic       rd_hit;                        // read address is mapped
   logic [7:0] rd_mux;                        // value at read address

   // ***************************************************************
   // register cells
   // ***************************************************************
   // each cell reloads its own reset value
   // one cell per register, plain storage
   for (genvar gi = 0; gi < NUM_REGS; gi++) begin : g_cell
      assign reg_hit[gi] = (reg_addr_in == REG_OFS[gi]);
      rtcr_reg_cell #(
         .RESET_VAL (REG_RST[gi])
      ) u_cell (
         .ref_clk_in (ref_clk_in),
         .rst_n_in   (rst_n_in),
         .wr_en_in   (reg_wr_in && reg_hit[gi]),
         .wdata_in   (reg_wdata_in),
         .value_out  (reg_val[gi])
      );
   end

   // ***************************************************************
   // read selection
   // ***************************************************************
   // pick the addressed value, holes read zero
   always_comb begin
      rd_hit = 1'b0;
      rd_mux = UNMAPPED_RD;
      for (int i = 0; i < NUM_REGS; i++) begin
         if (reg_hit[i]) begin
            rd_hit = 1'b1;
            rd_mux = reg_val[i];
         end
      end
   end

   // ***************************************************************
   // next state
   // ***************************************************************
   always_comb begin
      st_next = st_reg;
      // read data stands only in the cycle after the strobe
      st_next.rd_data = reg_rd_in ? rd_mux : UNMAPPED_RD;

      st_next.rate_rsvd = 1'b0;
      unique case (reg_val[IDX_RATE][RATE_LSB +: 3])
         RATE_848: st_next.rate_kbd = KBD_848;
         RATE_424: st_next.rate_kbd = KBD_424;
         RATE_212: st_next.rate_kbd = KBD_212;
         RATE_106: st_next.rate_kbd = KBD_106;
         default: begin
            // reserved codes, no rate offered
            st_next.rate_kbd  = 12'h000;
            st_next.rate_rsvd = 1'b1;
         end
      endcase

      // pulses per bit are a power of two
      if (reg_val[IDX_RXC1][SUBC_LSB +: 3] <= SUBC_MAX) begin
         st_next.subc_num  = 5'h01 << reg_val[IDX_RXC1][SUBC_LSB +: 3];
         st_next.subc_rsvd = 1'b0;
      end else begin
         // reserved codes, no count offered
         st_next.subc_num  = 5'h00;
         st_next.subc_rsvd = 1'b1;
      end

      st_next.gain_db = GAIN_DB[reg_val[IDX_RXC1][GAIN_LSB +: 2]];
   end

   // ***************************************************************
   // state register
   // ***************************************************************
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         st_reg <= '{UNMAPPED_RD, KBD_106, 1'b0, 5'h08, 1'b0, 6'h23};
      end else begin
         st_reg <= st_next;
      end
   end

   // ***************************************************************
   // modulation pulse timer
   // ***************************************************************
   // pulse length from the width register
   rtcr_mod_pulse u_mod_pulse (
      .ref_clk_in (ref_clk_in),
      .rst_n_in   (rst_n_in),
      .start_in   (mod_start_in),
      .width_in   (reg_val[IDX_MODW]),
      .pulse_out  (mod_pulse_out)
   );

   // ***************************************************************
   // outputs
   // ***************************************************************
   assign reg_rdata_out = st_reg.rd_data;

   assign driver_conductance_setting_out = reg_val[IDX_COND][COND_LSB +: 6];

   // raw rate code and its decode
   assign encoder_bit_rate_out      = reg_val[IDX_RATE][RATE_LSB +: 3];
   assign encoder_rate_kbd_out      = st_reg.rate_kbd;
   assign encoder_rate_reserved_out = st_reg.rate_rsvd;

   assign mod_pulse_width_count_out = reg_val[IDX_MODW];

   assign subcarrier_pulse_count_out = reg_val[IDX_RXC1][SUBC_LSB +: 3];
   assign subcarrier_pulses_out      = st_reg.subc_num;
   assign subcarrier_reserved_out    = st_reg.subc_rsvd;

   // bypass bit drives the filter control
   assign lowpass_bypass_out = reg_val[IDX_RXC1][LPF_BIT];

   // gain code and its decibel value
   assign rx_gain_code_out = reg_val[IDX_RXC1][GAIN_LSB +: 2];
   assign rx_gain_db_out   = st_reg.gain_db;

   // ***************************************************************
   // checks
   // ***************************************************************
   default clocking cb_main @(posedge ref_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   // a write to a given slot
   sequence s_wr_cond;
      reg_wr_in && reg_hit[IDX_COND];
   endsequence

   sequence s_wr_rate;
      reg_wr_in && reg_hit[IDX_RATE];
   endsequence

   sequence s_wr_modw;
      reg_wr_in && reg_hit[IDX_MODW];
   endsequence

   sequence s_wr_rxc1;
      reg_wr_in && reg_hit[IDX_RXC1];
   endsequence

   // a read of an address with no register behind it
   sequence s_rd_hole;
      reg_rd_in && !rd_hit;
   endsequence

   // write followed directly by a read of the same mapped address
   sequence s_wr_then_rd;
      (reg_wr_in && rd_hit) ##1 (reg_rd_in && (reg_addr_in == $past(reg_addr_in)));
   endsequence

   a_cond_reset: assert property (
      $rose(rst_n_in) |-> (driver_conductance_setting_out == 6'h3f))
      else $error("conductance not at reset value");

   a_cond_write: assert property (
      s_wr_cond |=> (driver_conductance_setting_out == $past(reg_wdata_in[5:0])))
      else $error("conductance field did not follow write");

   a_rate_reset: assert property (
      $rose(rst_n_in) |-> (encoder_bit_rate_out == RATE_106
                           && encoder_rate_kbd_out == KBD_106))
      else $error("encoder rate not at reset value");

   a_rate_decode: assert property (
      ##1 (encoder_rate_reserved_out == $past(encoder_bit_rate_out[2])))
      else $error("reserved rate flag wrong");

   a_width_reset: assert property (
      $rose(rst_n_in) |-> (mod_pulse_width_count_out == 8'h13))
      else $error("pulse width not at reset value");

   a_subc_count: assert property (
      (subcarrier_pulse_count_out <= SUBC_MAX) |=>
         (subcarrier_pulses_out == (5'h01 << $past(subcarrier_pulse_count_out))))
      else $error("subcarrier count decode wrong");

   a_lpf_write: assert property (
      s_wr_rxc1 |=> (lowpass_bypass_out == $past(reg_wdata_in[2])))
      else $error("low-pass bypass did not follow write");

   a_gain_decode: assert property (
      (rx_gain_code_out == 2'h2) |=> (rx_gain_db_out == 6'h1f))
      else $error("gain decode wrong");

   a_read_back: assert property (
      s_wr_then_rd |=> (reg_rdata_out == $past(reg_wdata_in, 2)))
      else $error("read did not return last write");

   a_read_quiet: assert property (
      (reg_rd_in && !reg_wr_in) |=> (rd_mux == $past(rd_mux) || $past(reg_addr_in) != reg_addr_in))
      else $error("read changed register contents");

   a_data_idle: assert property (
      !reg_rd_in |=> (reg_rdata_out == UNMAPPED_RD))
      else $error("read data outside answer cycle");

   a_rate_write: assert property (
      s_wr_rate |=>
         (encoder_bit_rate_out == $past(reg_wdata_in[RATE_LSB +: 3])))
      else $error("rate field did not follow write");

   a_rate_fast: assert property (
      (encoder_bit_rate_out == RATE_848) |=>
         (encoder_rate_kbd_out == KBD_848))
      else $error("848 rate decode wrong");

   a_rate_mid: assert property (
      (encoder_bit_rate_out == RATE_424) |=>
         (encoder_rate_kbd_out == KBD_424))
      else $error("424 rate decode wrong");

   a_rate_low: assert property (
      (encoder_bit_rate_out == RATE_212) |=>
         (encoder_rate_kbd_out == KBD_212))
      else $error("212 rate decode wrong");

   a_width_write: assert property (
      s_wr_modw |=>
         (mod_pulse_width_count_out == $past(reg_wdata_in)))
      else $error("pulse width did not follow write");

   a_subc_write: assert property (
      s_wr_rxc1 |=>
         (subcarrier_pulse_count_out == $past(reg_wdata_in[SUBC_LSB +: 3])))
      else $error("subcarrier code did not follow write");

   a_subc_reserved: assert property (
      (subcarrier_pulse_count_out > SUBC_MAX) |=>
         (subcarrier_reserved_out && subcarrier_pulses_out == 5'h00))
      else $error("reserved subcarrier code not flagged");

   a_gain_write: assert property (
      s_wr_rxc1 |=>
         (rx_gain_code_out == $past(reg_wdata_in[GAIN_LSB +: 2])))
      else $error("gain code did not follow write");

   a_gain_low: assert property (
      (rx_gain_code_out == 2'h0) |=>
         (rx_gain_db_out == 6'h14))
      else $error("20 dB gain decode wrong");

   a_hole_read: assert property (
      s_rd_hole |=>
         (reg_rdata_out == UNMAPPED_RD))
      else $error("unmapped read returned data");

   a_cond_hold: assert property (
      !reg_wr_in |=>
         $stable(driver_conductance_setting_out))
      else $error("conductance changed without a write");

   a_pulse_quiet: assert property (
      (!mod_pulse_out && !mod_start_in) |=>
         !mod_pulse_out)
      else $error("modulation pulse without a request");

endmodule : rtcr_top

`default_nettype wire

// ===== verification/rtcr_top_tb_top.sv
// self-checking testbench of the transmit and receive configuration bank
`timescale 1ns/1ps
`default_nettype none

module rtcr_top_tb_top
   import rtcr_pkg::*;
;
   // ***************************************************************
   // signals
   // ***************************************************************
   logic              ref_clk_in = 1'b0; // system clock
   logic              rst_n_in;      // synchronous reset, low
   logic [ADDR_W-1:0] reg_addr_in;   // register address
   logic [7:0]        reg_wdata_in;  // write data
   logic              reg_wr_in;     // write strobe
   logic              reg_rd_in;     // read strobe
   logic [7:0]        reg_rdata_out; // read data
   logic              mod_start_in;  // pulse request
   logic              mod_pulse_out; // modulation pulse
   logic [5:0]        cond_out;      // conductance field
   logic [2:0]        rate_out;      // rate code
   logic [11:0]       kbd_out;       // rate in kBd
   logic              rate_res_out;  // rate code reserved
   logic [7:0]        width_out;     // pulse width field
   logic [2:0]        subc_out;      // subcarrier code
   logic [4:0]        pulses_out;    // pulses per bit
   logic              subc_res_out;  // subcarrier code reserved
   logic              lpf_out;       // low-pass bypass
   logic [1:0]        gain_out;      // gain code
   logic [5:0]        db_out;        // gain in dB
   int                failures;      // mismatches seen
   int                cmp_count;     // comparisons made
   int                n;             // measured pulse length
   logic [7:0]        v;             // register value under test
   logic [2:0]        c3;            // code under test
   logic [7:0]        wid_tab [3] = '{8'h00, 8'h03, 8'hff}; // pulse widths tried

   // ***************************************************************
   // device under test
   // ***************************************************************
   rtcr_top DUT (
      .ref_clk_in                     (ref_clk_in),
      .rst_n_in                       (rst_n_in),
      .reg_addr_in                    (reg_addr_in),
      .reg_wdata_in                   (reg_wdata_in),
      .reg_wr_in                      (reg_wr_in),
      .reg_rd_in                      (reg_rd_in),
      .reg_rdata_out                  (reg_rdata_out),
      .mod_start_in                   (mod_start_in),
      .mod_pulse_out                  (mod_pulse_out),
      .driver_conductance_setting_out (cond_out),
      .encoder_bit_rate_out           (rate_out),
      .encoder_rate_kbd_out           (kbd_out),
      .encoder_rate_reserved_out      (rate_res_out),
      .mod_pulse_width_count_out      (width_out),
      .subcarrier_pulse_count_out     (subc_out),
      .subcarrier_pulses_out          (pulses_out),
      .subcarrier_reserved_out        (subc_res_out),
      .lowpass_bypass_out             (lpf_out),
      .rx_gain_code_out               (gain_out),
      .rx_gain_db_out                 (db_out)
   );

   // clock at 20 MHz, 50 ns period
   always #25 ref_clk_in = ~ref_clk_in;

   // ***************************************************************
   // tasks
   // ***************************************************************
   // verdict and end of run
   task automatic final_report();
      $display("checks=%0d failures=%0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : final_report

   // compare one value, count and report
   task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_val

   // one bus cycle, taken at the next rising edge
   task automatic bus_cycle(input logic wr, input logic rd, input logic [5:0] a,
                            input logic [7:0] d);
      reg_wr_in    <= wr;
      reg_rd_in    <= rd;
      reg_addr_in  <= a;
      reg_wdata_in <= d;
      @(posedge ref_clk_in);
   endtask : bus_cycle

   // strobes low for n edges, then let outputs settle
   task automatic idle(input int cnt);
      reg_wr_in <= 1'b0;
      reg_rd_in <= 1'b0;
      repeat (cnt) @(posedge ref_clk_in);
      #1;
   endtask : idle

   // register write
   task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
      bus_cycle(1'b1, 1'b0, a, d);
   endtask : wr_reg

   // register read, data looked at in the answer cycle only
   task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
      bus_cycle(1'b0, 1'b1, a, 8'h00);
      #1;
      check_val(16'(reg_rdata_out), 16'(exp));
   endtask : rd_chk

   // request one pulse and measure its length; retrig pokes start mid-pulse
   task automatic pulse_run(input logic retrig, output int len);
      int k;
      len = 0;
      mod_start_in <= 1'b1;
      @(posedge ref_clk_in);
      mod_start_in <= 1'b0;
      for (k = 0; k < 600; k++) begin
         #1;
         if (mod_pulse_out !== 1'b1) break;
         len++;
         mod_start_in <= retrig && (len == 2);
         @(posedge ref_clk_in);
      end
      mod_start_in <= 1'b0;
      // a pulse that never ends is a hang
      if (k == 600) begin
         failures++;
         final_report();
      end
   endtask : pulse_run

   // ***************************************************************
   // main sequence
   // ***************************************************************
   initial begin
      rst_n_in     = 1'b0;
      reg_addr_in  = '0;
      reg_wdata_in = 8'h00;
      reg_wr_in    = 1'b0;
      reg_rd_in    = 1'b0;
      mod_start_in = 1'b0;
      failures     = 0;
      cmp_count    = 0;
      repeat (8) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      // reset values of every register, reads back to back
      for (int i = 0; i < 7; i++) begin
         rd_chk(REG_OFS[i], REG_RST[i]);
      end
      idle(1);
      check_val(16'(reg_rdata_out), 16'h0000);
      check_val(16'(cond_out), 16'h003f);
      check_val(16'(kbd_out), 16'h006a);
      check_val(16'(width_out), 16'h0013);
      check_val(16'(pulses_out), 16'h0008);
      check_val(16'(lpf_out), 16'h0000);
      check_val(16'(db_out), 16'h0023);
      // holes read zero and ignore writes
      wr_reg(6'h18, 8'ha5);
      wr_reg(6'h11, 8'h5a);
      rd_chk(6'h18, 8'h00);
      rd_chk(6'h3f, 8'h00);
      rd_chk(6'h19, 8'h73);
      rd_chk(6'h12, 8'h3f);
      idle(1);
      // pulse length at the reset width
      pulse_run(1'b0, n);
      check_val(16'(n), 16'h0028);
      // conductance patterns, fixed upper bits written back as zero
      for (int i = 0; i < 4; i++) begin
         v = {2'b00, 6'h15 * 6'(i)};
         wr_reg(6'h12, v);
         idle(2);
         check_val(16'(cond_out), 16'(v[5:0]));
         rd_chk(6'h12, v);
      end
      // pulse widths, with a start during the width 3 pulse that must be dropped
      for (int i = 0; i < 3; i++) begin
         wr_reg(6'h15, wid_tab[i]);
         rd_chk(6'h15, wid_tab[i]);
         idle(1);
         check_val(16'(width_out), 16'(wid_tab[i]));
         pulse_run(i == 1, n);
         check_val(16'(n), 16'(2 * (int'(wid_tab[i]) + 1)));
      end
      // every encoder rate code
      for (int c = 0; c < 8; c++) begin
         c3 = 3'(c);
         v = {2'b00, c3, 3'b001};
         wr_reg(6'h14, v);
         idle(2);
         check_val(16'(rate_out), 16'(c3));
         check_val(16'(rate_res_out), 16'(c3[2]));
         case (c3)
            3'h0: check_val(16'(kbd_out), 16'h0350);
            3'h1: check_val(16'(kbd_out), 16'h01a8);
            3'h2: check_val(16'(kbd_out), 16'h00d4);
            3'h3: check_val(16'(kbd_out), 16'h006a);
            default: check_val(16'(kbd_out), 16'h0000);
         endcase
         rd_chk(6'h14, v);
      end
      // every subcarrier code, fixed bits kept
      for (int c = 0; c < 8; c++) begin
         c3 = 3'(c);
         v = {c3, 5'b10011};
         wr_reg(6'h19, v);
         idle(2);
         check_val(16'(subc_out), 16'(c3));
         check_val(16'(pulses_out), 16'((c3 <= 3'h4) ? (5'h01 << c3) : 5'h00));
         check_val(16'(subc_res_out), 16'(c3 > 3'h4));
         rd_chk(6'h19, v);
      end
      // every gain code, bypass bit toggled alongside
      for (int g = 0; g < 4; g++) begin
         v = {3'b011, 2'b10, 1'(g), 2'(g)};
         wr_reg(6'h19, v);
         idle(2);
         check_val(16'(lpf_out), 16'(g % 2));
         check_val(16'(gain_out), 16'(g));
         check_val(16'(db_out), 16'(GAIN_DB[g]));
         rd_chk(6'h19, v);
      end
      // second reset in mid-run restores the defaults
      idle(1);
      rst_n_in <= 1'b0;
      repeat (2) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      rd_chk(6'h14, 8'h19);
      rd_chk(6'h15, 8'h13);
      rd_chk(6'h19, 8'h73);
      rd_chk(6'h12, 8'h3f);
      idle(2);
      check_val(16'(kbd_out), 16'h006a);
      check_val(16'(db_out), 16'h0023);
      final_report();
   end

endmodule : rtcr_top_tb_top

`default_nettype wire
